// ---- rtl/lcr_router.sv ----
`timescale 1ns/1ps
// Summary of operation
// - One or two 64-bit read/write slave ports face the processor.
// - One or two 64-bit read/write master ports face the next memory level.
// - With two masters and no filter, uncached reads and unbuffered writes follow their slave port number.
// - With two masters, linefills, store buffer and eviction traffic may leave on either master.
// - With filtering on, in-range traffic goes to master 1 and all else to master 0.
// - With one master, master 1 is absent and master 0 carries everything.
// - Way size is a 3-bit select from 16KB to 512KB, default 001 meaning 16KB.
// - Associativity is 8 or 16 ways, default 0 for 8, 16 only when built in.
// - Slave ID width parameter is at least 2, default 5 giving 6 slave and 8 master ID bits.
// - Only slave zero implies only master zero, and filtering needs master one.
// - Banking, parity, both lockdowns, early read, filtering and sideband are optional builds.
// - A cache line is 32 bytes, four 64-bit beats.
module lcr_router
#(
    parameter bit SECOND_SLAVE_OPTION      = 1'b0,
    parameter bit SECOND_MASTER_OPTION     = 1'b0,
    parameter bit RANGE_REDIRECT_OPTION    = 1'b0,
    parameter bit SIXTEEN_WAY_OPTION       = 1'b0,
    parameter bit DATA_BANK_OPTION         = 1'b0,
    parameter bit PARITY_OPTION            = 1'b0,
    parameter bit PER_REQUESTER_LOCK_OPTION = 1'b0,
    parameter bit PER_LINE_LOCK_OPTION     = 1'b0,
    parameter bit EARLY_READ_OPTION        = 1'b0,
    parameter bit MASTER_SIDEBAND_OPTION   = 1'b0,
    parameter int SLAVE_ID_WIDTH_PARAM     = lcr_pkg::ID_MAX_DEF,
    parameter int ADDR_W                   = 32
)
(
    input  wire logic                ref_clk_in,
    input  wire logic                rst_in,
    input  wire logic [2:0]          way_size_select_in,
    input  wire logic                assoc_select_in,
    input  wire logic [2:0]          ram_latency_in,
    input  wire logic                filter_enable_in,
    input  wire logic [ADDR_W-1:0]   filter_start_in,
    input  wire logic [ADDR_W-1:0]   filter_end_in,
    input  wire logic                req_valid_in,
    output logic                     req_ready_out,
    input  wire logic [1:0]          req_src_in,
    input  wire logic [2:0]          req_class_in,
    input  wire logic [ADDR_W-1:0]   slave_request_address_in,
    input  wire logic [7:0]          slave_burst_length_in,
    input  wire logic [2:0]          slave_beat_size_in,
    input  wire logic [1:0]          slave_burst_type_in,
    input  wire logic                alt_master_in,
    input  wire logic [7:0]          user_sideband_in,
    output logic                     m0_valid_out,
    output logic                     m1_valid_out,
    input  wire logic                m_ready_in,
    output logic [ADDR_W-1:0]        m_addr_out,
    output logic                     m_full_line_out,
    output logic [7:0]               master_read_user_sideband_out,
    output logic [7:0]               master_write_user_sideband_out,
    output logic [2:0]               way_size_out,
    output logic                     sixteen_ways_out,
    output logic [3:0]               ram_cycles_out,
    output logic [7:0]               slave_id_bits_out,
    output logic [7:0]               master_id_bits_out
);
    localparam int DEPTH = 2;

    // Build checks
    initial
    begin
        if (SLAVE_ID_WIDTH_PARAM < lcr_pkg::ID_MAX_MIN)
            $error("slave id width parameter below minimum");
        if (!SECOND_SLAVE_OPTION && SECOND_MASTER_OPTION)
            $error("second master needs second slave");
        if (RANGE_REDIRECT_OPTION && !SECOND_MASTER_OPTION)
            $error("range redirect needs second master");
        if (lcr_pkg::LINE_BEATS != 4)
            $error("line must be four beats");
    end

    typedef struct packed
    {
        logic [DEPTH-1:0]             vld;
        logic [DEPTH-1:0]             port;
        logic [DEPTH-1:0]             full;
        logic [DEPTH-1:0][ADDR_W-1:0] addr;
        logic [DEPTH-1:0][7:0]        user;
        logic [DEPTH-1:0]             is_rd;
        logic                         wp;
        logic                         rp;
        logic [2:0]                   way;
        logic                         ways16;
        logic [3:0]                   lat;
        logic                         rdy;
        logic                         m0v;
        logic                         m1v;
        logic [ADDR_W-1:0]            oaddr;
        logic                         ofull;
        logic [7:0]                   rsb;
        logic [7:0]                   wsb;
    } lcr_state_s;

    lcr_state_s st_r;
    lcr_state_s st_nxt;

    // Full-line burst detection
    function automatic logic full_line(input logic [7:0] len,
                                       input logic [2:0] sz,
                                       input logic [1:0] bt,
                                       input logic [ADDR_W-1:0] a);
        logic aligned;
        aligned = (a[lcr_pkg::LINE_ADDR_HI:lcr_pkg::LINE_ADDR_LO] == 2'h0);
        full_line = (len == lcr_pkg::FULL_LEN) &&
                    (sz == lcr_pkg::FULL_SIZE) &&
                    ((bt == lcr_pkg::BURST_INCR && aligned) ||
                     bt == lcr_pkg::BURST_WRAP);
    endfunction

    // Master port choice for one request
    function automatic logic pick_port(input logic [1:0] src,
                                       input logic [2:0] cls,
                                       input logic [ADDR_W-1:0] a,
                                       input logic alt);
        logic p;
        p = 1'b0;
        if (!SECOND_MASTER_OPTION)
            p = 1'b0;
        else if (RANGE_REDIRECT_OPTION && filter_enable_in)
            p = (a >= filter_start_in) && (a <= filter_end_in);
        else if (cls == lcr_pkg::LCR_NONCACHE_RD ||
                 cls == lcr_pkg::LCR_NONBUF_WR)
            p = (src == lcr_pkg::LCR_SRC_SP1);
        else
            p = alt;
        pick_port = p;
    endfunction

    logic push;
    logic pop;
    logic src_ok;

    assign src_ok    = SECOND_SLAVE_OPTION ||
                       (req_src_in != lcr_pkg::LCR_SRC_SP1);
    assign push      = req_valid_in && req_ready_out && src_ok;
    assign pop       = st_r.vld[st_r.rp] && m_ready_in;

    // Next state: buffer and configuration
    always_comb
    begin
        st_nxt = st_r;
        if (pop)
        begin
            st_nxt.vld[st_r.rp] = 1'b0;
            st_nxt.rp = ~st_r.rp;
        end
        if (push)
        begin
            st_nxt.vld[st_r.wp]  = 1'b1;
            st_nxt.port[st_r.wp] = pick_port(req_src_in, req_class_in,
                                             slave_request_address_in,
                                             alt_master_in);
            st_nxt.full[st_r.wp] = full_line(slave_burst_length_in,
                                             slave_beat_size_in,
                                             slave_burst_type_in,
                                             slave_request_address_in);
            st_nxt.addr[st_r.wp] = slave_request_address_in;
            st_nxt.user[st_r.wp] = MASTER_SIDEBAND_OPTION ?
                                   user_sideband_in : 8'h00;
            st_nxt.is_rd[st_r.wp] =
                (req_class_in == lcr_pkg::LCR_NONCACHE_RD) ||
                (req_class_in == lcr_pkg::LCR_LINEFILL) ||
                (req_class_in == lcr_pkg::LCR_STB_ALLOC_RD);
            st_nxt.wp = ~st_r.wp;
        end
        // Way size, out-of-range codes fall back to default
        if (way_size_select_in >= lcr_pkg::WAY_SIZE_MIN &&
            way_size_select_in <= lcr_pkg::WAY_SIZE_MAX)
            st_nxt.way = way_size_select_in;
        else
            st_nxt.way = lcr_pkg::WAY_SIZE_DEF;
        st_nxt.ways16 = SIXTEEN_WAY_OPTION && assoc_select_in;
        st_nxt.lat = {1'b0, ram_latency_in} + 4'h1;
        // Head word copies, so every output except the ID widths leaves a flip-flop
        st_nxt.rdy   = !st_nxt.vld[st_nxt.wp];
        st_nxt.m0v   = st_nxt.vld[st_nxt.rp] &&
                       !st_nxt.port[st_nxt.rp];
        st_nxt.m1v   = SECOND_MASTER_OPTION && st_nxt.vld[st_nxt.rp] &&
                       st_nxt.port[st_nxt.rp];
        st_nxt.oaddr = st_nxt.addr[st_nxt.rp];
        st_nxt.ofull = st_nxt.full[st_nxt.rp];
        st_nxt.rsb   = st_nxt.is_rd[st_nxt.rp] ?
                       st_nxt.user[st_nxt.rp] : 8'h00;
        st_nxt.wsb   = st_nxt.is_rd[st_nxt.rp] ?
                       8'h00 : st_nxt.user[st_nxt.rp];
    end

    // State register
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_r        <= '0;
            st_r.way    <= lcr_pkg::WAY_SIZE_DEF;
            st_r.ways16 <= lcr_pkg::ASSOC_DEF;
            st_r.lat    <= {1'b0, lcr_pkg::LAT_DEF} + 4'h1;
            st_r.rdy    <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // Outputs straight from the state, ID widths from the parameter
    always_comb
    begin
        req_ready_out = st_r.rdy;
        m0_valid_out = st_r.m0v;
        m1_valid_out = st_r.m1v;
        m_addr_out = st_r.oaddr;
        m_full_line_out = st_r.ofull;
        master_read_user_sideband_out = st_r.rsb;
        master_write_user_sideband_out = st_r.wsb;
        way_size_out = st_r.way;
        sixteen_ways_out = st_r.ways16;
        ram_cycles_out = st_r.lat;
        slave_id_bits_out = 8'(SLAVE_ID_WIDTH_PARAM + 1);
        master_id_bits_out = 8'(SLAVE_ID_WIDTH_PARAM + 1 +
                                lcr_pkg::MST_ID_EXTRA);
    end

    // Checks
    no_m1_single_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !SECOND_MASTER_OPTION |-> !m1_valid_out)
        else $error("master 1 active when absent");
    one_port_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !(m0_valid_out && m1_valid_out))
        else $error("both masters valid");
    nc_route_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (push && SECOND_MASTER_OPTION && !(RANGE_REDIRECT_OPTION &&
         filter_enable_in) && req_class_in == lcr_pkg::LCR_NONCACHE_RD &&
         st_r.vld == '0) |=> (m1_valid_out ==
         ($past(req_src_in) == lcr_pkg::LCR_SRC_SP1)))
        else $error("uncached read on wrong master");
    lat_range_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ram_cycles_out >= 4'h1 && ram_cycles_out <= 4'h8)
        else $error("ram latency out of range");
    ways_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !SIXTEEN_WAY_OPTION |-> !sixteen_ways_out)
        else $error("sixteen ways without build");
    way_size_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        way_size_out >= lcr_pkg::WAY_SIZE_MIN &&
        way_size_out <= lcr_pkg::WAY_SIZE_MAX)
        else $error("way size code out of range");
    stall_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (m0_valid_out && !m_ready_in) |=> (m0_valid_out &&
         $stable(m_addr_out)))
        else $error("stalled word lost");
    sideband_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !MASTER_SIDEBAND_OPTION |-> (master_read_user_sideband_out == 8'h00
         && master_write_user_sideband_out == 8'h00))
        else $error("sideband driven when absent");
    c_m0: cover property (@(posedge ref_clk_in) m0_valid_out && m_ready_in);
    c_m1: cover property (@(posedge ref_clk_in) m1_valid_out && m_ready_in);
    c_full: cover property (@(posedge ref_clk_in) !req_ready_out);
    c_line: cover property (@(posedge ref_clk_in) m_full_line_out);
endmodule

// ---- common/lcr_pkg.sv ----
package lcr_pkg;
    // Beat and line geometry
    localparam int DATA_W        = 64;
    localparam int LINE_BYTES    = 32;
    localparam int BEAT_BYTES    = DATA_W / 8;
    localparam int LINE_BEATS    = LINE_BYTES / BEAT_BYTES;
    // Full-line burst shape
    localparam logic [7:0] FULL_LEN   = 8'h03;
    localparam logic [2:0] FULL_SIZE  = 3'h3;
    localparam logic [1:0] BURST_INCR = 2'h1;
    localparam logic [1:0] BURST_WRAP = 2'h2;
    localparam int LINE_ADDR_LO  = 3;
    localparam int LINE_ADDR_HI  = 4;
    // Configuration encodings and defaults
    localparam logic [2:0] WAY_SIZE_DEF = 3'h1;
    localparam logic [2:0] WAY_SIZE_MIN = 3'h1;
    localparam logic [2:0] WAY_SIZE_MAX = 3'h6;
    localparam logic       ASSOC_DEF    = 1'h0;
    localparam logic [2:0] LAT_DEF      = 3'h7;
    localparam int         ID_MAX_DEF   = 5;
    localparam int         ID_MAX_MIN   = 2;
    localparam int         MST_ID_EXTRA = 2;
    // Transaction classes
    typedef enum logic [2:0]
    {
        LCR_NONCACHE_RD,
        LCR_NONBUF_WR,
        LCR_LINEFILL,
        LCR_STB_ALLOC_RD,
        LCR_STB_BUF_WR,
        LCR_EVICT_WR
    } lcr_class_e;
    // Requester of a transaction
    typedef enum logic [1:0]
    {
        LCR_SRC_SP0,
        LCR_SRC_SP1,
        LCR_SRC_STB,
        LCR_SRC_EB
    } lcr_src_e;
endpackage

// ---- verif/lcr_mem_model.sv ----
`timescale 1ns/1ps
// Downstream memory stand-in, stalls when told, counts accepted words
module lcr_mem_model
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        m0_valid_in,
    input  wire logic        m1_valid_in,
    input  wire logic        stall_in,
    output logic             m_ready_out,
    output logic [15:0]      taken_out
);
    // Ready follows the stall request directly
    assign m_ready_out = !stall_in;

    // Count words taken on either master port
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            taken_out <= 16'h0;
        else if ((m0_valid_in || m1_valid_in) && m_ready_out)
            taken_out <= taken_out + 16'h1;
    end
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  way_sel = 3'h1;
    logic        assoc = 1'h0;
    logic [2:0]  lat = 3'h7;
    logic        flt_en = 1'h0;
    logic        req_valid = 1'h0;
    logic [1:0]  src = 2'h0;
    logic [2:0]  cls = 3'h0;
    logic [31:0] addr = 32'h0;
    logic [7:0]  blen = 8'h0;
    logic [1:0]  btype = 2'h1;
    logic        alt = 1'h0;
    logic        stall = 1'h1;
    logic [2:0]  bsize = lcr_pkg::FULL_SIZE;
    logic [7:0]  sband = 8'h00;
    logic        req_ready, m0_v, m1_v, m_ready, full, sixteen;
    logic [31:0] m_addr;
    logic [7:0]  rd_sb, wr_sb, sid_bits, mid_bits;
    logic [2:0]  way_out;
    logic [3:0]  ram_cyc;
    logic [15:0] taken;
    int          err_total = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          words = 0;
    localparam logic [31:0] F_LO = 32'h1000_0000;
    localparam logic [31:0] F_HI = 32'h1fff_ffff;

    // Clock and hang guard
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_total++;
            test_done();
        end
    end

    lcr_router #(.SECOND_SLAVE_OPTION(1'b1), .SECOND_MASTER_OPTION(1'b1),
        .RANGE_REDIRECT_OPTION(1'b1), .SIXTEEN_WAY_OPTION(1'b1),
        .MASTER_SIDEBAND_OPTION(1'b1)) lcr_router_inst (
        .ref_clk_in(ref_clk), .rst_in(rst), .way_size_select_in(way_sel),
        .assoc_select_in(assoc), .ram_latency_in(lat),
        .filter_enable_in(flt_en), .filter_start_in(F_LO),
        .filter_end_in(F_HI), .req_valid_in(req_valid),
        .req_ready_out(req_ready), .req_src_in(src), .req_class_in(cls),
        .slave_request_address_in(addr), .slave_burst_length_in(blen),
        .slave_beat_size_in(bsize), .slave_burst_type_in(btype),
        .alt_master_in(alt), .user_sideband_in(sband), .m0_valid_out(m0_v),
        .m1_valid_out(m1_v), .m_ready_in(m_ready), .m_addr_out(m_addr),
        .m_full_line_out(full), .master_read_user_sideband_out(rd_sb),
        .master_write_user_sideband_out(wr_sb), .way_size_out(way_out),
        .sixteen_ways_out(sixteen), .ram_cycles_out(ram_cyc),
        .slave_id_bits_out(sid_bits), .master_id_bits_out(mid_bits));

    lcr_mem_model lcr_mem_model_inst (.ref_clk_in(ref_clk), .rst_in(rst),
        .m0_valid_in(m0_v), .m1_valid_in(m1_v), .stall_in(stall),
        .m_ready_out(m_ready), .taken_out(taken));

    // Present one request and hold it until taken
    task automatic send(input logic [1:0] s, input logic [2:0] c,
                        input logic [31:0] a, input logic [7:0] l,
                        input logic [1:0] b, input logic al);
        int n;
        @(posedge ref_clk);
        req_valid <= 1'h1;
        src <= s;
        cls <= c;
        addr <= a;
        blen <= l;
        btype <= b;
        alt <= al;
        sband <= a[11:4] ^ 8'h5a;
        for (n = 0; n < 20; n++)
        begin
            @(negedge ref_clk);
            if (req_ready === 1'b1)
                break;
        end
        if (n == 20)
            err_total++;
        @(posedge ref_clk);
        req_valid <= 1'h0;
    endtask

    // Judge the head word, then let the model take it
    task automatic look(input logic [31:0] a, input logic e1, input logic f,
                        input logic [2:0] c);
        int n;
        logic [7:0] sb;
        sb = a[11:4] ^ 8'h5a;
        @(negedge ref_clk);
        for (n = 0; n < 20 && !(m0_v === 1'b1 || m1_v === 1'b1); n++)
            @(negedge ref_clk);
        `CHK("m1_valid", e1, m1_v)
        `CHK("m0_valid", !e1, m0_v)
        `CHK("m_addr", a, m_addr)
        `CHK("full_line", f, full)
        if (c == 3'h0 || c == 3'h2 || c == 3'h3)
        begin
            `CHK("rd_sideband", sb, rd_sb)
            `CHK("wr_sideband", 8'h00, wr_sb)
        end
        else
        begin
            `CHK("wr_sideband", sb, wr_sb)
            `CHK("rd_sideband", 8'h00, rd_sb)
        end
        @(posedge ref_clk);
        stall <= 1'h0;
        @(posedge ref_clk);
        stall <= 1'h1;
        words++;
    endtask

    // One routed transfer with the full-line flag worked out here
    task automatic route(input logic [1:0] s, input logic [2:0] c,
                         input logic [31:0] a, input logic [7:0] l,
                         input logic [1:0] b, input logic al,
                         input logic e1);
        logic f;
        send(s, c, a, l, b, al);
        f = l == lcr_pkg::FULL_LEN && bsize == lcr_pkg::FULL_SIZE &&
            (b == lcr_pkg::BURST_WRAP ||
            (b == lcr_pkg::BURST_INCR && a[4:3] == 2'h0));
        look(a, e1, f, c);
    endtask

    // Reset state and fixed identifier widths
    task automatic reset_vals();
        `CHK("ram_cycles", 4'h8, ram_cyc)
        `CHK("way_size", 3'h1, way_out)
        `CHK("sixteen", 1'h0, sixteen)
        `CHK("ready", 1'h1, req_ready)
        `CHK("slave_id", 8'h6, sid_bits)
        `CHK("master_id", 8'h8, mid_bits)
    endtask

    // Every way size, latency and associativity code
    task automatic config_codes();
        int i;
        for (i = 0; i < 8; i++)
        begin
            @(posedge ref_clk);
            way_sel <= 3'(i);
            lat <= 3'(i);
            assoc <= i[0];
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            `CHK("way_size", (i >= 1 && i <= 6) ? 3'(i) : 3'h1, way_out)
            `CHK("ram_cycles", 4'(i + 1), ram_cyc)
            `CHK("sixteen", i[0], sixteen)
        end
    endtask

    // Each class with both master choices, filter off
    task automatic class_table();
        int c;
        int a;
        for (c = 0; c < 6; c++)
            for (a = 0; a < 2; a++)
                route(c < 2 ? 2'(a) : (c == 2 ? 2'(1 - a) : (c == 5 ?
                      2'h3 : 2'h2)), 3'(c), 32'h0000_0100 + 32'(c * 64),
                      lcr_pkg::FULL_LEN, lcr_pkg::BURST_INCR,
                      (c < 2) ? ~a[0] : a[0], a[0]);
    endtask

    // Range edges with the filter on, overriding port and master choice
    task automatic filter_edges();
        @(posedge ref_clk);
        flt_en <= 1'h1;
        route(2'h0, 3'h0, F_LO, 8'h3, lcr_pkg::BURST_WRAP, 1'h0, 1'h1);
        route(2'h2, 3'h4, F_HI, 8'h0, lcr_pkg::BURST_INCR, 1'h0, 1'h1);
        route(2'h1, 3'h1, F_LO - 1, 8'h3, 2'h1, 1'h1, 1'h0);
        route(2'h3, 3'h5, F_HI + 1, 8'h3, 2'h1, 1'h1, 1'h0);
        route(2'h0, 3'h2, 32'h1000_0008, 8'h3, 2'h1, 1'h0, 1'h1);
        @(posedge ref_clk);
        bsize <= 3'h2;
        route(2'h1, 3'h2, 32'h0000_0c00, 8'h3, 2'h2, 1'h1, 1'h0);
        @(posedge ref_clk);
        bsize <= lcr_pkg::FULL_SIZE;
        flt_en <= 1'h0;
    endtask

    // Fill both entries, see the third refused, drain in order
    task automatic fill_drain();
        send(2'h0, 3'h0, 32'h0000_0a00, 8'h3, 2'h2, 1'h0);
        send(2'h0, 3'h1, 32'h0000_0b00, 8'h3, 2'h2, 1'h0);
        @(posedge ref_clk);
        req_valid <= 1'h1;
        @(negedge ref_clk);
        `CHK("ready_full", 1'h0, req_ready)
        @(posedge ref_clk);
        req_valid <= 1'h0;
        look(32'h0000_0a00, 1'h0, 1'h1, 3'h0);
        look(32'h0000_0b00, 1'h0, 1'h1, 3'h1);
        @(negedge ref_clk);
        `CHK("ready_empty", 1'h1, req_ready)
        `CHK("words_taken", 16'(words), taken)
    endtask

    // Mid-run reset drops a held word and restores defaults
    task automatic mid_reset();
        send(2'h0, 3'h2, 32'h0000_0d00, 8'h3, 2'h2, 1'h0);
        @(posedge ref_clk);
        rst <= 1'b1;
        @(negedge ref_clk);
        `CHK("reset_m0", 1'h0, m0_v)
        `CHK("reset_ways", 1'h0, sixteen)
        @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        reset_vals();
        @(negedge ref_clk);
        `CHK("ways_after", 1'h1, sixteen)
        `CHK("words_after", 16'h0, taken)
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        reset_vals();
        config_codes();
        class_table();
        filter_edges();
        fill_drain();
        mid_reset();
        test_done();
    end
endmodule
